// *** common/hdio_pkg.sv ***
package hdio_pkg;

    localparam int unsigned HDIO_DATA_W   = 32;
    localparam int unsigned HDIO_AUX_W    = 4;
    localparam int unsigned HDIO_IDX_W    = 5;
    localparam int unsigned HDIO_AUX_IDX_W = 2;

    localparam logic [HDIO_DATA_W-1:0] HDIO_DATA_RST = 32'h0000_0000;
    localparam logic [HDIO_AUX_W-1:0]  HDIO_AUX_RST  = 4'h0;

    // Input strobe edge selection
    localparam logic HDIO_EDGE_RISING  = 1'b0;
    localparam logic HDIO_EDGE_FALLING = 1'b1;

    typedef enum logic [1:0] {
        HDIO_IN_DIRECT    = 2'h0,
        HDIO_IN_STROBE    = 2'h1,
        HDIO_IN_HANDSHAKE = 2'h2
    } hdio_in_mode_t;

    typedef enum logic [1:0] {
        HDIO_OUT_DIRECT    = 2'h0,
        HDIO_OUT_STROBE    = 2'h1,
        HDIO_OUT_HANDSHAKE = 2'h2
    } hdio_out_mode_t;

    typedef struct packed {
        hdio_in_mode_t  in_mode;
        logic           input_strobe_falling_select;
        hdio_out_mode_t out_mode;
    } hdio_cfg_t;

    typedef struct packed {
        logic                   valid;
        logic [HDIO_DATA_W-1:0] word;
    } hdio_out_word_t;

    typedef struct packed {
        logic                      set;
        logic [HDIO_AUX_IDX_W-1:0] index;
        logic                      value;
    } hdio_aux_bit_t;

    typedef struct packed {
        logic                   valid;
        logic [HDIO_DATA_W-1:0] word;
    } hdio_in_word_t;

endpackage

// *** verilog/hdio_port.sv ***
// Functional notes
// - Strobe mode, rising select: latch input word on rising request edge.
// - Strobe mode, falling select: latch input word on falling request edge.
// - Device holds input acknowledge until peripheral drops input request.
// - Output strobe mode: pulse output request per new word, no acknowledge.
// - Output handshake: next request only after acknowledge was seen high.
// - Software reads all 32 input lines as one word.
// - Software writes one word driving all 32 output lines.
// - Input bits selectable by index 0..31, each read as 0 or 1.
// - Auxiliary option: 4-bit auxiliary input, read whole or per bit.
// - Auxiliary option: four auxiliary output bits, index 0..3, set 0/1.
// - Polarity bit: 1 selects falling strobe edge, 0 selects rising.
// - Input handshake: store word before raising input acknowledge.
// - Output handshake: present word on lines first, then raise request.
`timescale 1ns/10ps
module hdio_port #(
    parameter bit AUX_PRESENT = 1'b1
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_b,
    input  wire hdio_pkg::hdio_cfg_t                  cfg,
    input  wire logic [hdio_pkg::HDIO_DATA_W-1:0]     parallel_input_port,
    input  wire logic                                 in_req,
    output logic                                      in_ack,
    output hdio_pkg::hdio_in_word_t                   in_word,
    output logic [hdio_pkg::HDIO_DATA_W-1:0]          in_direct_word,
    input  wire logic [hdio_pkg::HDIO_IDX_W-1:0]      in_bit_index,
    output logic                                      in_bit,
    input  wire hdio_pkg::hdio_out_word_t             out_wr,
    output logic                                      out_wr_ready,
    output logic [hdio_pkg::HDIO_DATA_W-1:0]          out_data,
    output logic                                      out_req,
    input  wire logic                                 out_ack,
    input  wire logic [hdio_pkg::HDIO_AUX_W-1:0]      auxiliary_input_port,
    output logic [hdio_pkg::HDIO_AUX_W-1:0]           aux_in_word,
    input  wire logic [hdio_pkg::HDIO_AUX_IDX_W-1:0]  aux_bit_index,
    output logic                                      aux_in_bit,
    input  wire hdio_pkg::hdio_aux_bit_t              aux_bit_wr,
    output logic [hdio_pkg::HDIO_AUX_W-1:0]           aux_out
);
    import hdio_pkg::*;

    typedef enum logic [2:0] {
        HDIO_IS_IDLE  = 3'b001,
        HDIO_IS_STORE = 3'b010,
        HDIO_IS_ACK   = 3'b100
    } hdio_in_state_t;

    typedef enum logic [2:0] {
        HDIO_OS_IDLE    = 3'b001,
        HDIO_OS_PRESENT = 3'b010,
        HDIO_OS_REQ     = 3'b100
    } hdio_out_state_t;

    // Pin synchronisers; data and request share the same delay so a
    // sampled word stays aligned with the strobe edge that qualifies it.
    logic [HDIO_DATA_W-1:0] din_meta;
    logic [HDIO_DATA_W-1:0] din_sync;
    logic [HDIO_AUX_W-1:0]  aux_meta;
    logic [HDIO_AUX_W-1:0]  aux_sync;
    logic                   req_meta;
    logic                   req_sync;
    logic                   req_prev;
    logic                   ack_meta;
    logic                   ack_sync;

    // Data lines: two flops each, reset to the idle word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            din_meta <= HDIO_DATA_RST;
            din_sync <= HDIO_DATA_RST;
        end else begin
            din_meta <= parallel_input_port;
            din_sync <= din_meta;
        end
    end

    // Auxiliary lines are slow levels, but still cross clock domains
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_meta <= HDIO_AUX_RST;
            aux_sync <= HDIO_AUX_RST;
        end else begin
            aux_meta <= auxiliary_input_port;
            aux_sync <= aux_meta;
        end
    end

    // Handshake pins; req_prev resets to the idle low level so that
    // leaving reset never looks like a strobe edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            req_meta <= in_req;
            req_sync <= req_meta;
            req_prev <= req_sync;
            ack_meta <= out_ack;
            ack_sync <= ack_meta;
        end
    end

    // Bit pickers shared by the main and auxiliary read paths
    function automatic logic pick_bit(input logic [HDIO_DATA_W-1:0] word,
                                      input logic [HDIO_IDX_W-1:0]  idx);
        pick_bit = word[idx];
    endfunction

    function automatic logic [HDIO_DATA_W-1:0] widen_aux(
        input logic [HDIO_AUX_W-1:0] aux
    );
        widen_aux = {{(HDIO_DATA_W-HDIO_AUX_W){1'b0}}, aux};
    endfunction

    function automatic logic [HDIO_IDX_W-1:0] widen_aux_idx(
        input logic [HDIO_AUX_IDX_W-1:0] idx
    );
        widen_aux_idx = {{(HDIO_IDX_W-HDIO_AUX_IDX_W){1'b0}}, idx};
    endfunction

    // Strobe edge on the synchronised request, either polarity
    function automatic logic edge_seen(input logic prev,
                                       input logic now,
                                       input logic falling);
        if (falling) begin
            edge_seen = prev && !now;
        end else begin
            edge_seen = !prev && now;
        end
    endfunction

    // Direct reads of the main input lines
    logic [HDIO_DATA_W-1:0] next_in_direct_word;
    logic                   next_in_bit;

    always_comb begin
        next_in_direct_word = din_sync;
        next_in_bit         = pick_bit(din_sync, in_bit_index);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_direct_word <= HDIO_DATA_RST;
            in_bit         <= 1'b0;
        end else begin
            in_direct_word <= next_in_direct_word;
            in_bit         <= next_in_bit;
        end
    end

    // Auxiliary ports; with the option absent the inputs read as zero
    // and bit writes are dropped, so software sees a stable idle port
    logic [HDIO_AUX_W-1:0]  next_aux_in_word;
    logic                   next_aux_in_bit;
    logic [HDIO_AUX_W-1:0]  next_aux_out;

    always_comb begin
        if (AUX_PRESENT) begin
            next_aux_in_word = aux_sync;
        end else begin
            next_aux_in_word = HDIO_AUX_RST;
        end
        next_aux_in_bit = pick_bit(widen_aux(next_aux_in_word),
                                   widen_aux_idx(aux_bit_index));
        next_aux_out = aux_out;
        if (AUX_PRESENT && aux_bit_wr.set) begin
            next_aux_out[aux_bit_wr.index] = aux_bit_wr.value;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_in_word <= HDIO_AUX_RST;
            aux_in_bit  <= 1'b0;
            aux_out     <= HDIO_AUX_RST;
        end else begin
            aux_in_word <= next_aux_in_word;
            aux_in_bit  <= next_aux_in_bit;
            aux_out     <= next_aux_out;
        end
    end

    // Input capture: strobe edge or request/acknowledge handshake
    hdio_in_state_t    in_state;
    hdio_in_state_t    next_in_state;
    hdio_in_word_t     next_in_word;
    logic              next_in_ack;
    logic              strobe_hit;

    always_comb begin
        // Pins and request share one delay, so the word stays aligned
        strobe_hit = edge_seen(req_prev, req_sync,
                               cfg.input_strobe_falling_select
                               == HDIO_EDGE_FALLING);
        next_in_state = in_state;
        next_in_word  = '{valid: 1'b0, word: in_word.word};
        unique case (in_state)
            HDIO_IS_IDLE: begin
                if (cfg.in_mode == HDIO_IN_STROBE && strobe_hit) begin
                    next_in_word = '{valid: 1'b1, word: din_sync};
                end else if (cfg.in_mode == HDIO_IN_HANDSHAKE
                             && req_sync) begin
                    // Request stays high until acknowledged
                    next_in_word  = '{valid: 1'b1, word: din_sync};
                    next_in_state = HDIO_IS_STORE;
                end
            end
            HDIO_IS_STORE: begin
                next_in_state = HDIO_IS_ACK;
            end
            HDIO_IS_ACK: begin
                if (!req_sync) begin
                    next_in_state = HDIO_IS_IDLE;
                end
            end
        endcase
        next_in_ack = (next_in_state == HDIO_IS_ACK);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_state <= HDIO_IS_IDLE;
            in_word  <= '{valid: 1'b0, word: HDIO_DATA_RST};
            in_ack   <= 1'b0;
        end else begin
            in_state <= next_in_state;
            in_word  <= next_in_word;
            in_ack   <= next_in_ack;
        end
    end

    // Output path: direct, strobe or handshake
    hdio_out_state_t        out_state;
    hdio_out_state_t        next_out_state;
    logic [HDIO_DATA_W-1:0] next_out_data;
    logic                   next_out_req;
    logic                   next_out_wr_ready;

    always_comb begin
        next_out_state = out_state;
        next_out_data  = out_data;
        unique case (out_state)
            HDIO_OS_IDLE: begin
                if (out_wr.valid && out_wr_ready) begin
                    // Whole word loads in one edge, never piecewise
                    next_out_data = out_wr.word;
                    if (cfg.out_mode != HDIO_OUT_DIRECT) begin
                        next_out_state = HDIO_OS_PRESENT;
                    end
                end
            end
            HDIO_OS_PRESENT: begin
                next_out_state = HDIO_OS_REQ;
            end
            HDIO_OS_REQ: begin
                if (cfg.out_mode != HDIO_OUT_HANDSHAKE) begin
                    next_out_state = HDIO_OS_IDLE;
                end else if (ack_sync) begin
                    // Acknowledge may come any time after the request;
                    // one still high from the last word ends this one
                    // early, which is why the far side must drop it
                    // before a new request rises
                    next_out_state = HDIO_OS_IDLE;
                end
            end
        endcase
        // Both flags decode the next state so they leave the flops
        // in the same cycle as the state itself
        next_out_req      = 1'b0;
        next_out_wr_ready = 1'b0;
        if (next_out_state == HDIO_OS_REQ) begin
            next_out_req = 1'b1;
        end
        if (next_out_state == HDIO_OS_IDLE) begin
            next_out_wr_ready = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_state    <= HDIO_OS_IDLE;
            out_data     <= HDIO_DATA_RST;
            out_req      <= 1'b0;
            out_wr_ready <= 1'b0;
        end else begin
            out_state    <= next_out_state;
            out_data     <= next_out_data;
            out_req      <= next_out_req;
            out_wr_ready <= next_out_wr_ready;
        end
    end

endmodule

// *** verification/hdio_periph.sv ***
`timescale 1ns/10ps
module hdio_periph (
    input  wire logic        sys_clk,
    input  wire logic        in_ack,
    input  wire logic        out_req,
    output logic [31:0]      pins,
    output logic             in_req,
    output logic             out_ack
);
    // Late enough that the sync stages see the request long before ack
    int   ack_dly = 2;
    logic acked;

    initial begin
        pins = 32'h0;
        in_req = 1'b0;
        out_ack = 1'b0;
        acked = 1'b0;
    end

    task automatic drive(input logic [31:0] w, input logic r);
        pins = w;
        in_req = r;
    endtask

    task automatic send(input logic [31:0] w);
        int n;
        n = 0;
        drive(w, 1'b1);
        while (!in_ack && n < 20) begin
            @(posedge sys_clk) #1;
            n++;
        end
        acked = in_ack;
        // Released lines show the inverse, never the stale word
        drive(~w, 1'b0);
        while (in_ack && n < 40) begin
            @(posedge sys_clk) #1;
            n++;
        end
    endtask

    always @(posedge sys_clk) begin
        if (out_req && !out_ack) begin
            repeat (ack_dly) @(posedge sys_clk);
            #1 out_ack = 1'b1;
        end else if (!out_req && out_ack) begin
            #1 out_ack = 1'b0;
        end
    end
endmodule

// *** verification/hdio_port_checker.sv ***
`timescale 1ns/10ps
module hdio_port_checker #(
    parameter bit AUX_PRESENT = 1'b1
) (
    input wire logic                     sys_clk,
    input wire logic                     rst_b,
    input wire hdio_pkg::hdio_cfg_t      cfg,
    input wire logic                     in_req,
    input wire logic                     in_ack,
    input wire hdio_pkg::hdio_in_word_t  in_word,
    input wire logic [31:0]              in_direct_word,
    input wire logic [4:0]               in_bit_index,
    input wire logic                     in_bit,
    input wire hdio_pkg::hdio_out_word_t out_wr,
    input wire logic                     out_wr_ready,
    input wire logic [31:0]              out_data,
    input wire logic                     out_req,
    input wire logic                     out_ack,
    input wire logic [3:0]               aux_in_word,
    input wire logic [1:0]               aux_bit_index,
    input wire logic                     aux_in_bit,
    input wire hdio_pkg::hdio_aux_bit_t  aux_bit_wr,
    input wire logic [3:0]               aux_out
);
    import hdio_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence one_pulse;
        out_req ##1 !out_req;
    endsequence
    chk_rise_capture: assert property (
        cfg.in_mode == HDIO_IN_STROBE && !cfg.input_strobe_falling_select
        && $rose(in_req) |-> ##[2:4] in_word.valid)
        else $error("no capture after rising strobe");
    chk_fall_capture: assert property (
        cfg.in_mode == HDIO_IN_STROBE && cfg.input_strobe_falling_select
        && $fell(in_req) |-> ##[2:4] in_word.valid)
        else $error("no capture after falling strobe");
    chk_ack_holds: assert property (in_ack && in_req |=> in_ack)
        else $error("input ack dropped while request high");
    chk_store_first: assert property (
        $rose(in_ack) |-> $past(in_word.valid))
        else $error("ack raised before word stored");
    chk_strobe_pulse: assert property (
        cfg.out_mode == HDIO_OUT_STROBE && $rose(out_req) |-> one_pulse)
        else $error("output strobe not one cycle");
    chk_req_waits_ack: assert property (
        cfg.out_mode == HDIO_OUT_HANDSHAKE && out_req && !out_ack
        |=> out_req) else $error("output request dropped before ack");
    chk_data_first: assert property (
        $rose(out_req) |-> $stable(out_data) && !out_wr_ready)
        else $error("request raised with data moving");
    chk_word_whole: assert property (
        out_wr.valid && out_wr_ready |=> out_data == $past(out_wr.word))
        else $error("output word not applied whole");
    chk_in_bit_sel: assert property (
        1'b1 |-> in_bit == in_direct_word[$past(in_bit_index)])
        else $error("input bit select wrong");
    chk_aux_bit_sel: assert property (
        1'b1 |-> aux_in_bit == aux_in_word[$past(aux_bit_index)])
        else $error("aux bit select wrong");
    chk_aux_bit_set: assert property (
        AUX_PRESENT && aux_bit_wr.set
        |=> aux_out[$past(aux_bit_wr.index)] == $past(aux_bit_wr.value))
        else $error("aux output bit not set");
endmodule

// *** verification/hdio_port_test.sv ***
`timescale 1ns/10ps
module hdio_port_test;
    import hdio_pkg::*;
    logic sys_clk, rst_b, in_req, in_ack, in_bit, out_wr_ready;
    logic out_req, out_ack, aux_in_bit;
    logic [31:0] parallel_input_port, in_direct_word, out_data;
    logic [4:0]  in_bit_index;
    logic [3:0]  auxiliary_input_port, aux_in_word, aux_out;
    logic [1:0]  aux_bit_index;
    logic [3:0]  noaux_in_word, noaux_out;
    hdio_cfg_t      cfg;
    hdio_in_word_t  in_word;
    hdio_out_word_t out_wr;
    hdio_aux_bit_t  aux_bit_wr;
    int bad_count = 0, n_checks = 0, cycles = 0;

    hdio_port hdio_port_i (.sys_clk, .rst_b, .cfg, .parallel_input_port,
        .in_req, .in_ack, .in_word, .in_direct_word, .in_bit_index, .in_bit,
        .out_wr, .out_wr_ready, .out_data, .out_req, .out_ack,
        .auxiliary_input_port, .aux_in_word, .aux_bit_index, .aux_in_bit,
        .aux_bit_wr, .aux_out);
    // Second copy without the auxiliary option, fed the same stimulus
    hdio_port #(.AUX_PRESENT(1'b0)) hdio_port_noaux_i (.sys_clk, .rst_b,
        .cfg, .parallel_input_port, .in_req, .in_ack(), .in_word(),
        .in_direct_word(), .in_bit_index, .in_bit(), .out_wr,
        .out_wr_ready(), .out_data(), .out_req(), .out_ack,
        .auxiliary_input_port, .aux_in_word(noaux_in_word),
        .aux_bit_index, .aux_in_bit(), .aux_bit_wr, .aux_out(noaux_out));
    hdio_periph periph_i (.sys_clk, .in_ack, .out_req,
        .pins(parallel_input_port), .in_req, .out_ack);

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic t_direct;
        periph_i.drive(32'h8000_0001, 1'b0);
        auxiliary_input_port = 4'h9;
        in_bit_index = 5'h1f;
        aux_bit_index = 2'h3;
        step(5);
        chk(in_direct_word, 32'h8000_0001);
        chk(in_bit, 1'b1);
        chk(aux_in_word, 4'h9);
        chk(noaux_in_word, 4'h0);
        in_bit_index = 5'h01;
        aux_bit_index = 2'h1;
        step(2);
        chk(in_bit, 1'b0);
        chk(aux_in_bit, 1'b0);
        $display("test direct done");
    endtask
    // Both edges are offered; only the selected one may capture
    task automatic t_strobe(input logic sel);
        int seen;
        logic [31:0] w;
        seen = 0;
        w = 32'h0;
        cfg.in_mode = HDIO_IN_STROBE;
        cfg.input_strobe_falling_select = sel;
        periph_i.drive(32'h1234_5678, 1'b0);
        step(5);
        for (int k = 0; k < 2; k++) begin
            periph_i.drive(k ? 32'h00c3_3c00 : 32'h1234_5678, !k);
            repeat (8) begin
                step(1);
                if (in_word.valid === 1'b1) begin
                    seen++;
                    w = in_word.word;
                end
            end
        end
        chk(seen, 1);
        chk(w, sel ? 32'h00c3_3c00 : 32'h1234_5678);
        chk(in_ack, 1'b0);
        $display("test strobe done");
    endtask
    task automatic t_in_hs;
        cfg.in_mode = HDIO_IN_HANDSHAKE;
        step(4);
        periph_i.send(32'hcafe_0042);
        chk(periph_i.acked, 1'b1);
        chk(in_word.word, 32'hcafe_0042);
        chk(in_ack, 1'b0);
        $display("test input handshake done");
    endtask
    task automatic t_out(input hdio_out_mode_t m, input logic [31:0] w);
        int n, p;
        n = 0;
        p = 0;
        cfg.out_mode = m;
        step(2);
        out_wr = '{1'b1, w};
        while (out_wr_ready !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        step(1);
        out_wr.valid = 1'b0;
        repeat (12) begin
            step(1);
            p += out_req;
        end
        chk(out_data, w);
        chk(m == HDIO_OUT_DIRECT ? p == 0 : m == HDIO_OUT_STROBE ? p == 1
            : p > 1, 1'b1);
        chk({out_req, out_wr_ready}, 2'h1);
        $display("test output done");
    endtask
    task automatic t_aux;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                aux_bit_wr = '{1'b1, 2'(i), p[0] ^ ~i[0]};
                step(1);
            end
            aux_bit_wr.set = 1'b0;
            step(1);
            chk(aux_out, p ? 4'ha : 4'h5);
            chk(noaux_out, 4'h0);
        end
        $display("test aux done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        rst_b = 1'b0;
        cfg = '0;
        out_wr = '0;
        aux_bit_wr = '0;
        in_bit_index = 5'h0;
        aux_bit_index = 2'h0;
        auxiliary_input_port = 4'h0;
        step(4);
        rst_b = 1'b1;
        step(2);
        t_direct();
        t_strobe(HDIO_EDGE_RISING);
        t_strobe(HDIO_EDGE_FALLING);
        t_in_hs();
        t_out(HDIO_OUT_DIRECT, 32'h0f0f_a5a5);
        t_out(HDIO_OUT_STROBE, 32'hffff_ffff);
        t_out(HDIO_OUT_HANDSHAKE, 32'h0000_0001);
        t_aux();
        conclude();
    end
endmodule

bind hdio_port hdio_port_checker #(.AUX_PRESENT(AUX_PRESENT))
    hdio_port_checker_i (.sys_clk, .rst_b, .cfg, .in_req, .in_ack,
    .in_word, .in_direct_word, .in_bit_index, .in_bit, .out_wr,
    .out_wr_ready, .out_data, .out_req, .out_ack, .aux_in_word,
    .aux_bit_index, .aux_in_bit, .aux_bit_wr, .aux_out);
